// file: design/cpu_dram_refresh_arbiter_glue.sv
// Glue between a 32-bit processor bus and a DRAM controller with forced refresh
`timescale 1ns/1ps
`default_nettype none
module cpu_dram_refresh_arbiter_glue #(
    parameter bit BYTE_CAS_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Processor bus
    input wire logic addr_strobe_n_in,
    input wire logic chip_sel_n_in,
    input wire logic data_strobe_n_in,
    input wire logic read_in,
    input wire logic [dram_glue_pkg::BANK_W-1:0] bank_addr_in,
    input wire logic [dram_glue_pkg::LANES-1:0] byte_lane_in,
    // Controller and strap pins
    input wire logic refresh_request_line_n_in,
    input wire logic refresh_clock_in,
    input wire logic zero_wait_select_n_in,
    // Controller controls
    output logic row_request_n_out,
    output logic refresh_go_n_out,
    output logic ctrl_mode_bit0_out,
    output logic ctrl_mode_bit2_out,
    // Processor answers, byte strobes and previous bank
    output logic data_acknowledge_n_out,
    output logic [dram_glue_pkg::LANES-1:0] byte_we_n_out,
    output logic [dram_glue_pkg::LANES-1:0] byte_cas_n_out,
    output logic [dram_glue_pkg::BANK_W-1:0] previous_bank_out
);
    import dram_glue_pkg::*;

    glue_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] row_age_ff, nxt_row_age;
    logic [CNT_W-1:0] prech_cnt_ff, nxt_prech_cnt;
    logic [CNT_W-1:0] gap_cnt_ff;
    logic ref_pend_ff, nxt_ref_pend;
    logic rclk_prev_ff;
    logic last_was_ref_ff;
    logic row_request_n_ff, nxt_row_request_n;
    logic refresh_go_n_ff, nxt_refresh_go_n;
    logic [1:0] mode_ff;
    logic ack_n_ff;
    logic [LANES-1:0] we_n_ff, nxt_we_n;
    logic [LANES-1:0] cas_n_ff, nxt_cas_n;
    logic [BANK_W-1:0] previous_bank_ff;
    logic [BANK_W-1:0] bank_before_ff;
    logic [2:0] pins_sync;

    // Lanes pulled low when the strobe qualifies them
    function automatic logic [LANES-1:0] lanes_low(input logic hit, input logic [LANES-1:0] sel);
        lanes_low = hit ? ~sel : LANES_IDLE;
    endfunction

    // Refresh request, refresh clock and the wait strap come from outside this clock
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .pin_in({refresh_request_line_n_in, refresh_clock_in, zero_wait_select_n_in}),
        .sync_out(pins_sync)
    );

    // Synchronised pin levels and request decode
    wire rreq_n_sync = pins_sync[2];
    wire rclk_sync = pins_sync[1];
    wire zero_wait = !pins_sync[0];
    wire access_req = !chip_sel_n_in && !addr_strobe_n_in;
    wire ref_event = rclk_prev_ff && !rclk_sync && !rreq_n_sync;
    wire prech_done = (prech_cnt_ff == CNT_ZERO);
    wire other_bank = !BYTE_CAS_VARIANT && !last_was_ref_ff
        && (bank_addr_in != previous_bank_ff);
    wire bank_ok = prech_done || other_bank;
    wire nxt_in_access = (nxt_state == ST_ACC) || (nxt_state == ST_ACK);
    wire nxt_in_refresh = (nxt_state == ST_REF_GO) || (nxt_state == ST_REF_ROW);
    wire ref_taken = (state_ff == ST_IDLE) && (nxt_state == ST_REF_GO);
    wire acc_taken = (state_ff == ST_IDLE) && (nxt_state == ST_ACC);
    wire row_ended = !row_request_n_ff && nxt_row_request_n;

    // Sequencer: refresh only from idle, so an access in flight always finishes first
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ref_pend_ff && prech_done) begin
                    nxt_state = ST_REF_GO;
                end else if (access_req && bank_ok) begin
                    nxt_state = ST_ACC;
                    nxt_cnt = zero_wait ? CNT_ZERO : ACC_WAIT_CNT;
                end
            end
            ST_ACC: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ST_ACK;
                end else begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            ST_ACK: begin
                if (addr_strobe_n_in) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_REF_GO: begin
                nxt_state = ST_REF_ROW;
                nxt_cnt = zero_wait ? (REF_CNT - CNT_ONE) : REF_CNT;
            end
            ST_REF_ROW: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Row request age; the byte strobe variant drops the row request after a fixed time
    always_comb begin
        nxt_row_age = CNT_ZERO;
        if (nxt_in_access && state_ff != ST_IDLE) begin
            nxt_row_age = (row_age_ff < ROW_EARLY_CNT) ? row_age_ff + CNT_ONE : row_age_ff;
        end
    end

    // Controller line decode; the column strobes stay latched after the early row end
    assign nxt_row_request_n = !((nxt_state == ST_REF_ROW)
        || (nxt_in_access && (!BYTE_CAS_VARIANT || nxt_row_age < ROW_EARLY_CNT)));
    assign nxt_refresh_go_n = !nxt_in_refresh;
    assign nxt_ref_pend = ref_event || (ref_pend_ff && !ref_taken);
    assign nxt_prech_cnt = row_ended ? PRECH_CNT
        : (prech_done ? CNT_ZERO : prech_cnt_ff - CNT_ONE);

    // Byte strobes: write enables for the first variant, held column strobes for the second
    assign nxt_we_n = BYTE_CAS_VARIANT ? LANES_IDLE
        : lanes_low(nxt_in_access && !read_in && !data_strobe_n_in, byte_lane_in);
    assign nxt_cas_n = (BYTE_CAS_VARIANT && nxt_in_access)
        ? (cas_n_ff & lanes_low(!data_strobe_n_in, read_in ? LANES_ALL : byte_lane_in))
        : LANES_IDLE;

    // State and counters
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            cnt_ff <= CNT_ZERO;
            row_age_ff <= CNT_ZERO;
            prech_cnt_ff <= CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            row_age_ff <= nxt_row_age;
            prech_cnt_ff <= nxt_prech_cnt;
        end
    end

    // Refresh bookkeeping; a new refresh edge beats the clear of the pending flag
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ref_pend_ff <= 1'b0;
            rclk_prev_ff <= LINE_IDLE;
            last_was_ref_ff <= 1'b0;
        end else begin
            ref_pend_ff <= nxt_ref_pend;
            rclk_prev_ff <= rclk_sync;
            last_was_ref_ff <= ref_taken || (last_was_ref_ff && !acc_taken);
        end
    end

    // Bank memory for the interleave comparison
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            previous_bank_ff <= BANK_RESET;
            bank_before_ff <= BANK_RESET;
        end else if (acc_taken) begin
            previous_bank_ff <= bank_addr_in;
            bank_before_ff <= previous_bank_ff;
        end
    end

    // Registered outputs, all updated on the rising edge
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            row_request_n_ff <= LINE_IDLE;
            refresh_go_n_ff <= LINE_IDLE;
            mode_ff <= MODE_ACCESS;
            ack_n_ff <= LINE_IDLE;
            we_n_ff <= LANES_IDLE;
            cas_n_ff <= LANES_IDLE;
        end else begin
            row_request_n_ff <= nxt_row_request_n;
            refresh_go_n_ff <= nxt_refresh_go_n;
            mode_ff <= nxt_in_refresh ? MODE_REFRESH : MODE_ACCESS;
            ack_n_ff <= (nxt_state != ST_ACK);
            we_n_ff <= nxt_we_n;
            cas_n_ff <= nxt_cas_n;
        end
    end

    // Output wiring straight from the flip-flops
    assign row_request_n_out = row_request_n_ff;
    assign refresh_go_n_out = refresh_go_n_ff;
    assign ctrl_mode_bit2_out = mode_ff[1];
    assign ctrl_mode_bit0_out = mode_ff[0];
    assign data_acknowledge_n_out = ack_n_ff;
    assign byte_we_n_out = we_n_ff;
    assign byte_cas_n_out = cas_n_ff;
    assign previous_bank_out = previous_bank_ff;

    // Helper: cycles the row request has stood high, saturating
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            gap_cnt_ff <= CNT_MAX;
        end else if (!row_request_n_ff) begin
            gap_cnt_ff <= CNT_ZERO;
        end else if (gap_cnt_ff != CNT_MAX) begin
            gap_cnt_ff <= gap_cnt_ff + CNT_ONE;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Row pulse and acknowledge shapes
    sequence ref_row_long;
        !row_request_n_out [*3] ##1 row_request_n_out;
    endsequence
    sequence ref_row_short;
        !row_request_n_out [*2] ##1 row_request_n_out;
    endsequence
    sequence ack_after_wait;
        data_acknowledge_n_out [*2] ##1 !data_acknowledge_n_out;
    endsequence

    a_start_on_select: assert property (
        $fell(row_request_n_out) && refresh_go_n_out
        |-> $past(!chip_sel_n_in && !addr_strobe_n_in))
        else $error("Access started without select and strobe");

    a_refresh_from_idle: assert property (
        $fell(refresh_go_n_out) |-> $past(row_request_n_out && data_acknowledge_n_out))
        else $error("Refresh began during an access");

    a_no_hidden_refresh: assert property (
        !refresh_go_n_out |-> data_acknowledge_n_out && byte_we_n_out == LANES_IDLE)
        else $error("Access overlapped a refresh");

    a_refresh_mode_zero: assert property (
        !refresh_go_n_out |-> !ctrl_mode_bit0_out && !ctrl_mode_bit2_out)
        else $error("Refresh without mode zero");

    a_row_after_go: assert property (
        $fell(refresh_go_n_out) |=> $fell(row_request_n_out))
        else $error("Row request did not follow refresh output");

    a_refresh_length_long: assert property (
        $fell(row_request_n_out) && !refresh_go_n_out && !$past(zero_wait)
        |-> ref_row_long)
        else $error("Refresh row pulse not three cycles");

    a_refresh_length_short: assert property (
        $fell(row_request_n_out) && !refresh_go_n_out && $past(zero_wait)
        |-> ref_row_short)
        else $error("Shortened refresh row pulse not two cycles");

    a_wait_state_ack: assert property (
        $fell(row_request_n_out) && refresh_go_n_out && !$past(zero_wait)
        |-> ack_after_wait)
        else $error("Acknowledge not delayed by one wait state");

    a_zero_wait_ack: assert property (
        $fell(row_request_n_out) && refresh_go_n_out && $past(zero_wait)
        |-> data_acknowledge_n_out ##1 !data_acknowledge_n_out)
        else $error("Zero wait access acknowledge late");

    a_same_bank_gap: assert property (
        $fell(row_request_n_out) && refresh_go_n_out
        && (previous_bank_out == bank_before_ff || BYTE_CAS_VARIANT)
        |-> gap_cnt_ff >= 3'h3)
        else $error("Row precharge too short before access");

    a_early_row_end: assert property (
        BYTE_CAS_VARIANT && $fell(row_request_n_out) && refresh_go_n_out
        |-> !row_request_n_out [*2] ##1 row_request_n_out)
        else $error("Row request not ended early");

    a_write_enable_cause: assert property (
        byte_we_n_out != LANES_IDLE |-> $past(!read_in && !data_strobe_n_in)
        && !BYTE_CAS_VARIANT)
        else $error("Write enable without write strobe");

    a_pending_kept: assert property (
        ref_event && state_ff != ST_IDLE |=> ref_pend_ff)
        else $error("Refresh request lost");
endmodule
`default_nettype wire

// file: design/dram_glue_pkg.sv
// Shared constants and types for the processor to DRAM controller glue
package dram_glue_pkg;
    // Bus and counter widths
    localparam int BANK_W = 2;
    localparam int LANES = 4;
    localparam int CNT_W = 3;

    // Clock and timing figures, in nanoseconds
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROW_PRECH_MIN_NS = 75;
    localparam int REF_ROW_MIN_NS = 125;

    // Derived cycle counts; least times round up
    localparam int PRECH_CYC = (ROW_PRECH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_CYC = (REF_ROW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] PRECH_CNT = CNT_W'(PRECH_CYC);
    localparam logic [CNT_W-1:0] REF_CNT = CNT_W'(REF_CYC - 1);
    localparam logic [CNT_W-1:0] ACC_WAIT_CNT = 3'h1;
    localparam logic [CNT_W-1:0] ROW_EARLY_CNT = 3'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_MAX = 3'h7;

    // Controller mode pins {bit2, bit0}: access mode and forced refresh mode
    localparam logic [1:0] MODE_ACCESS = 2'h3;
    localparam logic [1:0] MODE_REFRESH = 2'h0;

    // Reset and idle values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [LANES-1:0] LANES_IDLE = 4'hF;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACC = 3'b001,
        ST_ACK = 3'b010,
        ST_REF_GO = 3'b011,
        ST_REF_ROW = 3'b100
    } glue_state_t;
endpackage

// file: design/pin_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Pin side and synchronised side
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// file: tb/refresh_ctrl_model.sv
// Behavioural model of the DRAM controller's refresh request pins
`timescale 1ns/1ps
`default_nettype none
module refresh_ctrl_model (
    // Clock and bench command
    input wire logic clock_in,
    input wire logic fire_in,
    // Glue outputs seen by the controller
    input wire logic row_request_n_in,
    input wire logic refresh_go_n_in,
    input wire logic ctrl_mode_bit0_in,
    input wire logic ctrl_mode_bit2_in,
    // Controller pins
    output logic refresh_request_line_n_out,
    output logic refresh_clock_out,
    output logic row_strobe_n_out
);
    logic [2:0] cnt_ff = 3'h0;
    logic req_n_ff = 1'b1;
    logic rclk_ff = 1'b1;

    // Row strobe follows the row request directly, with no bank decode
    assign row_strobe_n_out = row_request_n_in;

    // Pins come from single registers so each has one driver
    assign refresh_request_line_n_out = req_n_ff;
    assign refresh_clock_out = rclk_ff;

    // Request low, then one refresh clock fall; clock stands high otherwise
    always @(posedge clock_in) begin
        // Forced refresh in mode 0 clears the pending request
        if (!refresh_go_n_in && !ctrl_mode_bit2_in && !ctrl_mode_bit0_in) begin
            req_n_ff <= 1'b1;
        end
        // A new request wins over the clear in the same cycle
        if (fire_in) begin
            req_n_ff <= 1'b0;
            cnt_ff <= 3'h1;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
        if (cnt_ff == 3'h2) begin
            rclk_ff <= 1'b0;
        end
        if (cnt_ff == 3'h6) begin
            rclk_ff <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the processor to DRAM controller glue
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dram_glue_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic as_n = 1'b1, cs_n = 1'b1, ds_n = 1'b1, rd = 1'b1, zw_n = 1'b1, fire = 1'b0;
    logic [BANK_W-1:0] bank = BANK_RESET;
    logic [LANES-1:0] lanes = 4'h0;
    wire logic req_n, refresh_clock, row_n, go_n, m0, m2, ack_n, row_c;
    wire logic [LANES-1:0] we_n, cas_n;
    wire logic [BANK_W-1:0] prev;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;

    // Write enable variant drives the refresh model; byte strobe variant shares the bus
    cpu_dram_refresh_arbiter_glue #(.BYTE_CAS_VARIANT(1'b0)) dut (
        .clock_in(clock_in), .rst_in(rst_in), .addr_strobe_n_in(as_n),
        .chip_sel_n_in(cs_n), .data_strobe_n_in(ds_n), .read_in(rd),
        .bank_addr_in(bank), .byte_lane_in(lanes), .refresh_request_line_n_in(req_n),
        .refresh_clock_in(refresh_clock), .zero_wait_select_n_in(zw_n), .row_request_n_out(row_n),
        .refresh_go_n_out(go_n), .ctrl_mode_bit0_out(m0), .ctrl_mode_bit2_out(m2),
        .data_acknowledge_n_out(ack_n), .byte_we_n_out(we_n), .byte_cas_n_out(),
        .previous_bank_out(prev));
    cpu_dram_refresh_arbiter_glue #(.BYTE_CAS_VARIANT(1'b1)) dut_cas (
        .clock_in(clock_in), .rst_in(rst_in), .addr_strobe_n_in(as_n),
        .chip_sel_n_in(cs_n), .data_strobe_n_in(ds_n), .read_in(rd),
        .bank_addr_in(bank), .byte_lane_in(lanes), .refresh_request_line_n_in(req_n),
        .refresh_clock_in(refresh_clock), .zero_wait_select_n_in(zw_n), .row_request_n_out(row_c),
        .refresh_go_n_out(), .ctrl_mode_bit0_out(), .ctrl_mode_bit2_out(),
        .data_acknowledge_n_out(), .byte_we_n_out(), .byte_cas_n_out(cas_n),
        .previous_bank_out());
    refresh_ctrl_model ctrl (
        .clock_in(clock_in), .fire_in(fire), .row_request_n_in(row_n),
        .refresh_go_n_in(go_n), .ctrl_mode_bit0_in(m0), .ctrl_mode_bit2_in(m2),
        .refresh_request_line_n_out(req_n), .refresh_clock_out(refresh_clock),
        .row_strobe_n_out());

    // 20 MHz system clock
    initial begin
        forever #25 clock_in = ~clock_in;
    end

    task summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function logic pick(input int s);
        case (s)
            0: pick = ack_n;
            1: pick = go_n;
            default: pick = row_n;
        endcase
    endfunction

    // Counts falling edges until the chosen output reaches a level; bounded
    task wait_for(input int s, input logic lvl, output int cnt);
        cnt = 0;
        while (pick(s) !== lvl) begin
            @(negedge clock_in);
            cnt++;
            if (cnt > 60) begin
                n_mismatch++;
                summarize();
            end
        end
    endtask

    task start(input logic [1:0] b, input logic [3:0] l, input logic r);
        @(posedge clock_in);
        cs_n <= 1'b0;
        as_n <= 1'b0;
        ds_n <= 1'b0;
        rd <= r;
        bank <= b;
        lanes <= l;
    endtask

    // Strobes stay low until acknowledge, then are released together
    task end_acc;
        @(posedge clock_in);
        as_n <= 1'b1;
        cs_n <= 1'b1;
        ds_n <= 1'b1;
        wait_for(0, 1'b1, n);
        chk(8'(row_n), 8'h01);
        chk(8'(we_n), 8'h0F);
    endtask

    task t_select;
        @(posedge clock_in);
        as_n <= 1'b0;
        repeat (4) @(negedge clock_in);
        chk(8'(row_n), 8'h01);
        // Select alone must not start a cycle either
        @(posedge clock_in);
        as_n <= 1'b1;
        cs_n <= 1'b0;
        repeat (4) @(negedge clock_in);
        chk(8'(row_n), 8'h01);
        @(posedge clock_in);
        cs_n <= 1'b1;
    endtask

    task t_write;
        start(2'h1, 4'h6, 1'b0);
        wait_for(0, 1'b0, n);
        chk(8'(n), 8'h04);
        chk(8'(we_n), 8'h09);
        chk(8'(prev), 8'h01);
        chk(8'(row_c), 8'h01);
        chk(8'(cas_n), 8'h09);
        end_acc();
        // Other bank follows back to back, same bank waits for precharge
        start(2'h2, 4'hF, 1'b0);
        wait_for(0, 1'b0, n);
        chk(8'(n), 8'h04);
        end_acc();
        start(2'h2, 4'hF, 1'b0);
        wait_for(0, 1'b0, n);
        chk(8'(n), 8'h05);
        end_acc();
    endtask

    task t_read_zw;
        @(posedge clock_in);
        zw_n <= 1'b0;
        repeat (4) @(posedge clock_in);
        start(2'h3, 4'h5, 1'b1);
        wait_for(0, 1'b0, n);
        chk(8'(n), 8'h03);
        chk(8'(we_n), 8'h0F);
        chk(8'(cas_n), 8'h00);
        end_acc();
        // Let the strap pass the synchroniser before the next access
        @(posedge clock_in);
        zw_n <= 1'b1;
        repeat (3) @(posedge clock_in);
    endtask

    task t_defer;
        start(2'h0, 4'h3, 1'b0);
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        wait_for(0, 1'b0, n);
        // Hold the access open past the refresh clock fall so the request must wait
        repeat (6) @(negedge clock_in);
        chk(8'({go_n, ack_n}), 8'h02);
        end_acc();
        wait_for(1, 1'b0, n);
        chk(8'(n), 8'h03);
        chk(8'(row_n), 8'h01);
        wait_for(1, 1'b1, n);
    endtask

    task t_refresh(input logic z, input logic [7:0] rows);
        @(posedge clock_in);
        zw_n <= z;
        repeat (4) @(posedge clock_in);
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        wait_for(1, 1'b0, n);
        chk(8'({m2, m0}), 8'h00);
        wait_for(2, 1'b0, n);
        wait_for(2, 1'b1, n);
        chk(8'(n), rows);
        chk(8'({go_n, m2, m0}), 8'h07);
        @(posedge clock_in);
        zw_n <= 1'b1;
        repeat (6) @(posedge clock_in);
    endtask

    task t_during;
        @(posedge clock_in);
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        wait_for(1, 1'b0, n);
        start(2'h1, 4'hF, 1'b0);
        wait_for(0, 1'b0, n);
        chk(8'(go_n), 8'h01);
        chk(8'(n), 8'h09);
        end_acc();
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        t_select();
        t_write();
        t_read_zw();
        t_defer();
        t_refresh(1'b1, 8'h03);
        t_refresh(1'b0, 8'h02);
        t_during();
        summarize();
    end
endmodule
`default_nettype wire
